/* cic_pkg.sv */
/*
 * Shared constants, types and field layouts for the CPU interface
 * control register block.
 * Assumes a single core clock domain and a core that presents one
 * system register access at a time on a valid strobe.
 */
`default_nettype none

package cic_pkg;

   // Access encoding of the physical control register
   localparam logic [1:0] CTL_OP0 = 2'h3;
   localparam logic [2:0] CTL_OP1 = 3'h0;
   localparam logic [3:0] CTL_CRN = 4'hc;
   localparam logic [3:0] CTL_CRM = 4'hc;
   localparam logic [2:0] CTL_OP2 = 3'h4;

   // Exception levels as the core reports them
   localparam logic [1:0] UNPRIVILEGED_LEVEL = 2'h0;
   localparam logic [1:0] KERNEL_LEVEL       = 2'h1;
   localparam logic [1:0] HYPERVISOR_LEVEL   = 2'h2;
   localparam logic [1:0] MONITOR_LEVEL      = 2'h3;

   // Syndrome class reported with every trap
   localparam logic [5:0] TRAP_SYNDROME = 6'h18;

   // Field positions; only the first three are used by both control registers
   localparam int COMMON_BINARY_POINT_SELECT_BIT      = 0;
   localparam int EOI_MODE_BIT  = 1;
   localparam int PRI_LSB       = 8;
   localparam int ID_WIDTH_LSB  = 11;
   localparam int SEI_BIT       = 14;
   localparam int AFF3_BIT      = 15;
   localparam int RSS_BIT       = 18;
   localparam int EXT_RANGE_BIT = 19;

   // Read-only feature values of the virtual control register
   localparam logic       EXT_RANGE_VAL = 1'h1;
   localparam logic       RSS_VAL       = 1'h0;
   localparam logic       AFF3_VAL      = 1'h1;
   localparam logic       SEI_VAL       = 1'h0;
   localparam logic [2:0] ID_WIDTH_VAL  = 3'h0;

   // Reset values of the stored bits
   localparam logic COMMON_BINARY_POINT_SELECT_RST = 1'h0;
   localparam logic EOI_RST  = 1'h0;

   // Binary point saturation limit
   localparam logic [2:0] BPR_MAX = 3'h7;

   // Where an access ends up
   typedef enum logic [2:0] {
      RESP_MISS,
      RESP_UNDEFINED,
      RESP_TRAP_HYP,
      RESP_TRAP_MON,
      RESP_VIRTUAL,
      RESP_SECURE,
      RESP_NONSECURE
   } cic_route_e;

   // System register encoding of a request
   typedef struct packed {
      logic [1:0] op0;
      logic [2:0] op1;
      logic [3:0] crn;
      logic [3:0] crm;
      logic [2:0] op2;
   } cic_enc_s;

   // Processor context that steers the routing
   typedef struct packed {
      logic [1:0] level;
      logic       hypEnabled;
      logic       hypTrapCommon;
      logic       fiqRouteOverride;
      logic       irqRouteOverride;
      logic       monIrqRoute;
      logic       monFiqRoute;
      logic       nonsecureStateBit;
      logic       distSecurityDisable;
   } cic_ctx_s;

   // Answer to one access
   typedef struct packed {
      cic_route_e  route;
      logic [5:0]  syndrome;
      logic [63:0] rdata;
   } cic_resp_s;

endpackage

`default_nettype wire

/* cic_cpu_if_control.sv */
/*
 * Control register logic of an interrupt controller CPU interface:
 * access routing for system register reads and writes of the physical
 * control register, its banked binary point select and end of
 * interrupt mode bits, and the virtual control register.
 * Assumes the core drives requests and context from the same clock,
 * holds the context stable while a request is valid, and keeps the
 * binary point registers itself, handing their values in here.
 */
// How it works
// [RULE1] Clear select: each group uses own point
// [RULE2] Set select: group 0 point serves both
// [RULE3] Select bit aliases bank chosen by security
// [RULE4] Select bit writable only when security disabled or no monitor level exists
// [RULE5] Register matched by its fixed access encoding
// [RULE6] Unprivileged level access is undefined
// [RULE7] Kernel with trap-common traps to hypervisor
// [RULE8] Kernel with route override uses virtual copy
// [RULE9] Both monitor routes set trap to monitor
// [RULE10] Otherwise bank chosen by non-secure bit
// [RULE11] Extended identifier range reads one
// [RULE12] Range selector support reads zero
// [RULE13] Affinity-3 valid reads one, writes ignored
// [RULE14] System error support reads zero
// [RULE15] Identifier width reads zero, read-only
// [RULE16] Priority width reads bit count minus one
// [RULE17] Virtual split follows virtual binary points
// [RULE18] Reserved virtual fields read zero
// [RULE19] Common virtual point: group 1 reads plus one
// [RULE20] End of interrupt mode selects deactivation style
`default_nettype none

module cic_cpu_if_control
#(
   parameter int  PRI_BITS    = 5,   // Implemented priority bits
   parameter bit  HAS_MONITOR = 1'b1 // Highest exception level exists
)
(
   input  wire logic               clk,
   input  wire logic               resetn,
   input  wire logic               reqValid,
   input  wire logic               reqWrite,
   input  wire cic_pkg::cic_enc_s  reqEnc,
   input  wire logic [63:0]        reqWdata,
   input  wire cic_pkg::cic_ctx_s  ctx,
   input  wire logic [2:0]         group0BinaryPoint,
   input  wire logic [2:0]         group1BinaryPoint,
   input  wire logic [2:0]         virtualGroup0BinaryPoint,
   input  wire logic [2:0]         virtualGroup1BinaryPoint,
   output logic                    respValid,
   output cic_pkg::cic_resp_s      resp,
   output logic [2:0]              group0Preempt,
   output logic [2:0]              group1Preempt,
   output logic [2:0]              virtualGroup0Preempt,
   output logic [2:0]              virtualGroup1Preempt,
   output logic [2:0]              virtualGroup1ReadValue,
   output logic                    virtualGroup1WriteIgnore,
   output logic                    endOfInterruptMode,
   output logic                    virtualEndOfInterruptMode
);
   import cic_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Parameter checks

   // The priority width field holds three bits
   if (PRI_BITS < 1 || PRI_BITS > 8)
   begin : g_bad_pri
      $error("PRI_BITS must lie between 1 and 8");
   end

   localparam logic [2:0] PRI_FIELD = 3'(PRI_BITS - 1);

   ////////////////////////////////////////////////////////////////////
   // Routing decode

   // Resolves one access; earlier conditions take priority
   function automatic cic_route_e route_of(input cic_enc_s e,
                                          input cic_ctx_s c);
      logic hit;
      logic monRoute;
      cic_route_e bank;
      hit = (e.op0 == CTL_OP0) && (e.op1 == CTL_OP1) &&
            (e.crn == CTL_CRN) && (e.crm == CTL_CRM) &&
            (e.op2 == CTL_OP2);                          // [RULE5]
      monRoute = c.monIrqRoute && c.monFiqRoute;
      bank = c.nonsecureStateBit ? RESP_NONSECURE
                                 : RESP_SECURE;          // [RULE10]
      if (!hit)
      begin
         route_of = RESP_MISS;
      end
      else if (c.level == UNPRIVILEGED_LEVEL)
      begin
         route_of = RESP_UNDEFINED;                      // [RULE6]
      end
      else if (c.level == KERNEL_LEVEL && c.hypEnabled &&
               c.hypTrapCommon)
      begin
         route_of = RESP_TRAP_HYP;                       // [RULE7]
      end
      else if (c.level == KERNEL_LEVEL && c.hypEnabled &&
               (c.fiqRouteOverride || c.irqRouteOverride))
      begin
         route_of = RESP_VIRTUAL;                        // [RULE8]
      end
      else if (c.level != MONITOR_LEVEL && monRoute)
      begin
         route_of = RESP_TRAP_MON;                       // [RULE9]
      end
      else
      begin
         route_of = bank;                                // [RULE10]
      end
   endfunction

   // Saturating increment used for the common virtual binary point
   function automatic logic [2:0] sat_inc(input logic [2:0] v);
      sat_inc = (v == BPR_MAX) ? BPR_MAX : 3'(v + 3'h1);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Stored state

   logic cbprSecure_ff;       // Select bit, secure bank
   logic cbprNonsecure_ff;    // Select bit, non-secure bank
   logic eoiSecure_ff;        // End of interrupt mode, secure bank
   logic eoiNonsecure_ff;     // End of interrupt mode, non-secure bank
   logic vCbpr_ff;            // Virtual common binary point bit
   logic vEoi_ff;             // Virtual end of interrupt mode bit
   logic respValid_ff;        // Answer strobe
   cic_resp_s resp_ff;        // Answer payload

   ////////////////////////////////////////////////////////////////////
   // Access decode

   cic_route_e reqRoute;      // Destination of the current request
   logic       take;          // A request is present this cycle
   logic       wrSecure;      // Write lands in the secure bank
   logic       wrNonsecure;   // Write lands in the non-secure bank
   logic       wrVirtual;     // Write lands in the virtual copy
   logic       cbprWritable;  // Select bit may be changed
   logic       wCbpr;         // Select bit value being written
   logic       wEoi;          // Mode bit value being written

   assign reqRoute    = route_of(reqEnc, ctx);
   assign take        = reqValid;
   assign wrSecure    = take && reqWrite && (reqRoute == RESP_SECURE);
   assign wrNonsecure = take && reqWrite &&
                        (reqRoute == RESP_NONSECURE);
   assign wrVirtual   = take && reqWrite && (reqRoute == RESP_VIRTUAL);
   assign wCbpr       = reqWdata[COMMON_BINARY_POINT_SELECT_BIT];
   assign wEoi        = reqWdata[EOI_MODE_BIT];

   // Without a monitor level the bit is an ordinary read/write bit
   assign cbprWritable = !HAS_MONITOR ||
                         ctx.distSecurityDisable;        // [RULE4]

   ////////////////////////////////////////////////////////////////////
   // Next values of the banked bits

   logic nxt_cbprSecure_ff;
   logic nxt_cbprNonsecure_ff;
   logic nxt_eoiSecure_ff;
   logic nxt_eoiNonsecure_ff;
   logic nxt_vCbpr_ff;
   logic nxt_vEoi_ff;

   // The select bit lives in the top-level copy of each bank, so a
   // bank is written only through its own security state
   assign nxt_cbprSecure_ff    = (wrSecure && cbprWritable) ? wCbpr
                                 : cbprSecure_ff;        // [RULE3]
   assign nxt_cbprNonsecure_ff = (wrNonsecure && cbprWritable) ? wCbpr
                                 : cbprNonsecure_ff;     // [RULE3]
   assign nxt_eoiSecure_ff     = wrSecure ? wEoi : eoiSecure_ff;
   assign nxt_eoiNonsecure_ff  = wrNonsecure ? wEoi : eoiNonsecure_ff;
   assign nxt_vCbpr_ff         = wrVirtual ? wCbpr : vCbpr_ff;
   assign nxt_vEoi_ff          = wrVirtual ? wEoi : vEoi_ff;

   ////////////////////////////////////////////////////////////////////
   // Read values

   logic [63:0] physRead;     // Image of the selected physical bank
   logic [63:0] virtRead;     // Image of the virtual register
   logic        selCbpr;      // Select bit of the addressed bank
   logic        selEoi;       // Mode bit of the addressed bank

   assign selCbpr = (reqRoute == RESP_NONSECURE) ? cbprNonsecure_ff
                                                 : cbprSecure_ff;
   assign selEoi  = (reqRoute == RESP_NONSECURE) ? eoiNonsecure_ff
                                                 : eoiSecure_ff;

   // Only the fields this block owns are shown; the rest read zero
   always_comb
   begin
      physRead                              = 64'h0;
      physRead[PRI_LSB +: 3]                = PRI_FIELD;   // [RULE16]
      physRead[EOI_MODE_BIT]                = selEoi;
      physRead[COMMON_BINARY_POINT_SELECT_BIT]                    = selCbpr;     // [RULE3]
   end

   // Everything not named here is reserved and reads zero
   always_comb
   begin
      virtRead                    = 64'h0;                 // [RULE18]
      virtRead[EXT_RANGE_BIT]     = EXT_RANGE_VAL;         // [RULE11]
      virtRead[RSS_BIT]           = RSS_VAL;               // [RULE12]
      virtRead[AFF3_BIT]          = AFF3_VAL;              // [RULE13]
      virtRead[SEI_BIT]           = SEI_VAL;               // [RULE14]
      virtRead[ID_WIDTH_LSB +: 3] = ID_WIDTH_VAL;          // [RULE15]
      virtRead[PRI_LSB +: 3]      = PRI_FIELD;             // [RULE16]
      virtRead[EOI_MODE_BIT]      = vEoi_ff;
      virtRead[COMMON_BINARY_POINT_SELECT_BIT]          = vCbpr_ff;
   end

   ////////////////////////////////////////////////////////////////////
   // Answer assembly

   cic_resp_s nxt_resp_ff;    // Answer captured at the taking edge
   logic [63:0] ansData;      // Read data, zero for writes and faults
   logic [5:0]  ansSyndrome;  // Syndrome class, zero unless trapped

   assign ansData = reqWrite ? 64'h0
                  : (reqRoute == RESP_VIRTUAL) ? virtRead
                  : (reqRoute == RESP_SECURE ||
                     reqRoute == RESP_NONSECURE) ? physRead
                  : 64'h0;
   assign ansSyndrome = (reqRoute == RESP_TRAP_HYP ||
                         reqRoute == RESP_TRAP_MON)
                        ? TRAP_SYNDROME : 6'h0;        // [RULE7] [RULE9]
   assign nxt_resp_ff = '{route: reqRoute, syndrome: ansSyndrome,
                          rdata: ansData};

   ////////////////////////////////////////////////////////////////////
   // Registers

   // Banked control bits; writes take effect at the taking edge
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cbprSecure_ff    <= COMMON_BINARY_POINT_SELECT_RST;
         cbprNonsecure_ff <= COMMON_BINARY_POINT_SELECT_RST;
         eoiSecure_ff     <= EOI_RST;
         eoiNonsecure_ff  <= EOI_RST;
         vCbpr_ff         <= COMMON_BINARY_POINT_SELECT_RST;
         vEoi_ff          <= EOI_RST;
      end
      else
      begin
         cbprSecure_ff    <= nxt_cbprSecure_ff;
         cbprNonsecure_ff <= nxt_cbprNonsecure_ff;
         eoiSecure_ff     <= nxt_eoiSecure_ff;
         eoiNonsecure_ff  <= nxt_eoiNonsecure_ff;
         vCbpr_ff         <= nxt_vCbpr_ff;
         vEoi_ff          <= nxt_vEoi_ff;
      end
   end

   // One answer per request, registered at the edge that takes it
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         respValid_ff <= 1'b0;
         resp_ff      <= '0;
      end
      else
      begin
         respValid_ff <= take;
         if (take)
         begin
            resp_ff <= nxt_resp_ff;
         end
      end
   end

   assign respValid = respValid_ff;
   assign resp      = resp_ff;

   ////////////////////////////////////////////////////////////////////
   // Preemption grouping

   logic curNonsecure;        // Security state of the running code
   logic curCbpr;             // Select bit seen by the running code

   // The monitor level always runs secure
   assign curNonsecure = ctx.nonsecureStateBit &&
                         (ctx.level != MONITOR_LEVEL);
   assign curCbpr = curNonsecure ? cbprNonsecure_ff
                                 : cbprSecure_ff;        // [RULE3]

   assign group0Preempt = group0BinaryPoint;             // [RULE1]
   assign group1Preempt = curCbpr ? group0BinaryPoint    // [RULE2]
                                  : group1BinaryPoint;   // [RULE1]

   // Virtual split comes from the virtual binary points only
   assign virtualGroup0Preempt = virtualGroup0BinaryPoint; // [RULE17]
   assign virtualGroup1Preempt = vCbpr_ff ? virtualGroup0BinaryPoint
                               : virtualGroup1BinaryPoint; // [RULE17]

   // Group 1 reads follow group 0 while the common bit is set
   assign virtualGroup1ReadValue = vCbpr_ff
                                 ? sat_inc(virtualGroup0BinaryPoint)
                                 : virtualGroup1BinaryPoint; // [RULE19]
   assign virtualGroup1WriteIgnore = vCbpr_ff;           // [RULE19]

   ////////////////////////////////////////////////////////////////////
   // End of interrupt mode

   // Clear: completion drops priority and deactivates; set: it only
   // drops priority and a separate deactivate write is needed
   assign endOfInterruptMode = curNonsecure ? eoiNonsecure_ff
                                            : eoiSecure_ff; // [RULE20]
   assign virtualEndOfInterruptMode = vEoi_ff;           // [RULE20]

endmodule

`default_nettype wire

/* cic_cpu_if_control_assertions.sv */
/*
 * Port checker for the CPU interface control block.
 * Assumes one core clock domain; bound to the block at the file foot.
 */
`default_nettype none

module cic_cpu_if_control_assertions
#(
   parameter int PRI_BITS = 5 // Implemented priority bits
)
(
   input wire logic               clk,
   input wire logic               resetn,
   input wire logic               reqValid,
   input wire logic               reqWrite,
   input wire cic_pkg::cic_enc_s  reqEnc,
   input wire cic_pkg::cic_ctx_s  ctx,
   input wire logic [2:0]         virtualGroup0BinaryPoint,
   input wire logic [2:0]         virtualGroup1BinaryPoint,
   input wire logic               respValid,
   input wire cic_pkg::cic_resp_s resp,
   input wire logic [2:0]         virtualGroup1Preempt,
   input wire logic [2:0]         virtualGroup1ReadValue,
   input wire logic               virtualGroup1WriteIgnore
);
   timeunit 1ns;
   timeprecision 1ps;
   import cic_pkg::*;

   // Fixed part of a virtual read image, low two bits masked off
   localparam logic [63:0] V_IMG = (64'h1 << 19) | (64'h1 << 15)
                                 | (64'(PRI_BITS - 1) << 8);

   wire logic       hit;   // Taken request aimed at this register
   wire logic       kHyp;  // Kernel level with hypervisor enabled
   wire logic [2:0] sat;   // Group 0 virtual point plus one, capped
   assign hit  = reqValid && reqEnc == {CTL_OP0, CTL_OP1, CTL_CRN,
                                        CTL_CRM, CTL_OP2};
   assign kHyp = ctx.level == KERNEL_LEVEL && ctx.hypEnabled;
   assign sat  = (virtualGroup0BinaryPoint == BPR_MAX) ? BPR_MAX
               : virtualGroup0BinaryPoint + 3'h1;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   ////////////////////////////////////////////////////////////////////////
   a_answer_next_cycle: assert property (reqValid |=> respValid)
      else $error("request not answered in the next cycle");
   a_no_stray_answer: assert property (!reqValid |=> !respValid)
      else $error("answer without a request");
   a_unpriv_undefined: assert property (hit && ctx.level == 2'h0
      |=> resp.route == RESP_UNDEFINED && resp.rdata == 64'h0)
      else $error("unprivileged access not undefined");
   a_trap_to_hyp: assert property (hit && kHyp && ctx.hypTrapCommon
      |=> resp.route == RESP_TRAP_HYP && resp.syndrome == TRAP_SYNDROME)
      else $error("missing hypervisor trap");
   a_virtual_redirect: assert property (hit && kHyp
      && !ctx.hypTrapCommon && (ctx.fiqRouteOverride
      || ctx.irqRouteOverride) |=> resp.route == RESP_VIRTUAL)
      else $error("override did not reach the virtual copy");
   a_trap_to_mon: assert property (hit && ctx.level inside {2'h1, 2'h2}
      && !(kHyp && (ctx.hypTrapCommon || ctx.fiqRouteOverride
      || ctx.irqRouteOverride)) && ctx.monIrqRoute && ctx.monFiqRoute
      |=> resp.route == RESP_TRAP_MON && resp.syndrome == TRAP_SYNDROME)
      else $error("missing monitor trap");
   a_bank_by_ns: assert property (hit && ctx.level == MONITOR_LEVEL
      |=> resp.route == ($past(ctx.nonsecureStateBit) ? RESP_NONSECURE
      : RESP_SECURE)) else $error("wrong bank at monitor level");
   a_virtual_image: assert property (respValid && !$past(reqWrite)
      && resp.route == RESP_VIRTUAL |-> (resp.rdata & ~64'h3) == V_IMG)
      else $error("virtual read image fields wrong");
   a_vbp_saturate: assert property (virtualGroup1WriteIgnore
      |-> virtualGroup1ReadValue == sat)
      else $error("group 1 virtual read not saturated sum");
   a_virtual_split: assert property (virtualGroup1Preempt ==
      (virtualGroup1WriteIgnore ? virtualGroup0BinaryPoint
      : virtualGroup1BinaryPoint)) else $error("virtual preempt source");

   // Main scenarios reached
   cover property (hit && reqWrite && ctx.level == MONITOR_LEVEL);
   cover property (respValid && resp.route == RESP_VIRTUAL);
   cover property (respValid && resp.route == RESP_TRAP_MON);
endmodule

bind cic_cpu_if_control cic_cpu_if_control_assertions #(.PRI_BITS(PRI_BITS))
   chkInst (.clk, .resetn, .reqValid, .reqWrite, .reqEnc, .ctx,
            .virtualGroup0BinaryPoint, .virtualGroup1BinaryPoint,
            .respValid, .resp, .virtualGroup1Preempt,
            .virtualGroup1ReadValue, .virtualGroup1WriteIgnore);

`default_nettype wire

/* cic_core_model.sv */
/*
 * Model of the core that issues system register accesses.
 * Assumes tasks are entered in the time step of a rising clock edge.
 */
`default_nettype none

module cic_core_model
(
   input  wire logic              clk,
   output var  logic              reqValid,
   output var  logic              reqWrite,
   output var  cic_pkg::cic_enc_s reqEnc,
   output var  logic [63:0]       reqWdata,
   output var  cic_pkg::cic_ctx_s ctx
);
   timeunit 1ns;
   timeprecision 1ps;
   import cic_pkg::*;

   // Quiet lines at time zero
   initial
   begin
      reqValid = 1'b0;
      reqWrite = 1'b0;
      reqEnc   = '0;
      reqWdata = '0;
      ctx      = '0;
   end

   ////////////////////////////////////////////////////////////////////////
   // One access, held up to its taking edge; context stays put afterwards
   task automatic access(input logic w, input cic_enc_s e,
                         input logic [63:0] d, input cic_ctx_s c);
      reqValid <= 1'b1;
      reqWrite <= w;
      reqEnc   <= e;
      reqWdata <= d;
      ctx      <= c;
      @(posedge clk);
   endtask

   // Drop the strobe; stale fields scrambled so nothing leans on them
   task automatic idle();
      reqValid <= 1'b0;
      reqWrite <= ~reqWrite;
      reqEnc   <= ~reqEnc;
      reqWdata <= ~reqWdata;
   endtask
endmodule

`default_nettype wire

/* cic_cpu_if_control_tb.sv */
/*
 * Self-checking bench for the CPU interface control block.
 * Assumes the core model drives requests; bench drives points.
 */
`default_nettype none

module cic_cpu_if_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cic_pkg::*;

   localparam int PRI   = 5;     // Priority bits under test
   localparam int LIMIT = 12000; // Cycle ceiling for the whole run
   localparam cic_enc_s MATCH = {CTL_OP0, CTL_OP1, CTL_CRN, CTL_CRM,
                                 CTL_OP2};

   logic clk, resetn, reqValid, reqWrite, respValid;
   cic_enc_s reqEnc;
   cic_ctx_s ctx, mon;
   cic_resp_s resp;
   logic [63:0] reqWdata;
   logic [2:0] group0BinaryPoint, group1BinaryPoint, group0Preempt;
   logic [2:0] virtualGroup0BinaryPoint, virtualGroup1BinaryPoint;
   logic [2:0] group1Preempt, virtualGroup0Preempt, virtualGroup1Preempt;
   logic [2:0] virtualGroup1ReadValue;
   logic virtualGroup1WriteIgnore, endOfInterruptMode;
   logic virtualEndOfInterruptMode;
   logic cbS, cbN, eoS, eoN, vcb, veo; // Expected stored bits
   int mismatches, nChecks, cycles;

   cic_cpu_if_control #(.PRI_BITS(PRI)) cic_cpu_if_control_inst (.clk,
      .resetn, .reqValid, .reqWrite, .reqEnc, .reqWdata, .ctx,
      .group0BinaryPoint, .group1BinaryPoint, .virtualGroup0BinaryPoint,
      .virtualGroup1BinaryPoint, .respValid, .resp, .group0Preempt,
      .group1Preempt, .virtualGroup0Preempt, .virtualGroup1Preempt,
      .virtualGroup1ReadValue, .virtualGroup1WriteIgnore,
      .endOfInterruptMode, .virtualEndOfInterruptMode);
   cic_core_model cic_core_model_inst (.clk, .reqValid, .reqWrite,
      .reqEnc, .reqWdata, .ctx);

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   // Expected destination of one access, in priority order
   function automatic cic_route_e expRoute(cic_ctx_s c, cic_enc_s e);
      logic kh;
      kh = c.level == KERNEL_LEVEL && c.hypEnabled;
      if (e != MATCH) return RESP_MISS;
      if (c.level == UNPRIVILEGED_LEVEL) return RESP_UNDEFINED;
      if (kh && c.hypTrapCommon) return RESP_TRAP_HYP;
      if (kh && (c.fiqRouteOverride || c.irqRouteOverride))
         return RESP_VIRTUAL;
      if (c.level != MONITOR_LEVEL && c.monIrqRoute && c.monFiqRoute)
         return RESP_TRAP_MON;
      return c.nonsecureStateBit ? RESP_NONSECURE : RESP_SECURE;
   endfunction

   // Read image: feature bits only on the virtual copy
   function automatic logic [63:0] img(logic v, logic cb, logic eo);
      return (v ? ((64'h1 << 19) | (64'h1 << 15)) : 64'h0)
           | (64'(PRI - 1) << 8) | {62'h0, eo, cb};
   endfunction

   function automatic logic [2:0] satInc(logic [2:0] p);
      return (p == BPR_MAX) ? BPR_MAX : p + 3'h1;
   endfunction

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      nChecks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", nChecks, mismatches);
      if (mismatches == 0 && nChecks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // One access; only the last of a back-to-back run is checked here
   task automatic run(logic w, cic_enc_s e, logic [63:0] d, cic_ctx_s c,
                      logic last);
      cic_route_e r;
      logic ns, v;
      r = expRoute(c, e);
      v = r == RESP_VIRTUAL;
      ns = r == RESP_NONSECURE;
      group0BinaryPoint <= 3'($urandom);
      group1BinaryPoint <= 3'($urandom);
      virtualGroup0BinaryPoint <= 3'($urandom);
      virtualGroup1BinaryPoint <= 3'($urandom);
      cic_core_model_inst.access(w, e, d, c);
      if (last) cic_core_model_inst.idle();
      if (last)
      begin
         @(negedge clk);
         chk(respValid, 1'b1);
         chk(resp.route, r);
         if (r inside {RESP_TRAP_HYP, RESP_TRAP_MON})
            chk(resp.syndrome, TRAP_SYNDROME);
         if (!w && (v || r inside {RESP_SECURE, RESP_NONSECURE}))
            chk(resp.rdata, img(v, v ? vcb : ns ? cbN : cbS,
                v ? veo : ns ? eoN : eoS));
         if (r == RESP_UNDEFINED) chk(resp.rdata, 64'h0);
      end
      if (w && v) {veo, vcb} = d[1:0];
      if (w && ns) {eoN, cbN} = {d[1], c.distSecurityDisable ? d[0] : cbN};
      if (w && r == RESP_SECURE) {eoS, cbS} = {d[1], c.distSecurityDisable ? d[0] : cbS};
      if (!last) return;
      ns = c.nonsecureStateBit && c.level != MONITOR_LEVEL;
      chk(group0Preempt, group0BinaryPoint);
      chk(group1Preempt, (ns ? cbN : cbS) ? group0BinaryPoint
          : group1BinaryPoint);
      chk(endOfInterruptMode, ns ? eoN : eoS);
      chk(virtualGroup0Preempt, virtualGroup0BinaryPoint);
      chk(virtualGroup1Preempt, vcb ? virtualGroup0BinaryPoint
          : virtualGroup1BinaryPoint);
      chk(virtualGroup1ReadValue, vcb ? satInc(virtualGroup0BinaryPoint)
          : virtualGroup1BinaryPoint);
      chk({virtualGroup1WriteIgnore, virtualEndOfInterruptMode},
          {vcb, veo});
      @(posedge clk);
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         mismatches++;
         wrap_up();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(32'heade7fee));
      {mismatches, nChecks, cycles} = '0;
      {cbS, cbN, eoS, eoN, vcb, veo} = '0;
      resetn = 1'b0;
      {group0BinaryPoint, group1BinaryPoint} = '0;
      {virtualGroup0BinaryPoint, virtualGroup1BinaryPoint} = '0;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      // Protected select write then read back to back, then unprotected
      mon = '0;
      mon.level = MONITOR_LEVEL;
      for (int k = 0; k < 2; k++)
      begin
         mon.distSecurityDisable = k[0];
         run(1'b1, MATCH, 64'h3, mon, 1'b0);
         run(1'b0, MATCH, 64'h0, mon, 1'b1);
      end
      for (int k = 0; k < 900; k++)
         run(1'($urandom), ($urandom_range(7) == 0)
             ? cic_enc_s'(16'($urandom)) : MATCH, {$urandom, $urandom},
             cic_ctx_s'(10'($urandom)),
             $urandom_range(3) != 0);
      cic_core_model_inst.idle();
      // Reset in mid-run clears every stored bit
      @(posedge clk);
      resetn <= 1'b0;
      @(posedge clk);
      resetn <= 1'b1;
      {cbS, cbN, eoS, eoN, vcb, veo} = '0;
      @(posedge clk);
      run(1'b0, MATCH, 64'h0, mon, 1'b1);
      wrap_up();
   end
endmodule

`default_nettype wire
